/* rtl/dccb_pkg.sv */
// Package for the device configuration control bits block.
// Assumes an AHB-Lite slave with 32-bit data and word registers.
package dccb_pkg;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] OFF_DEFER_COUNT = 8'h10;
  localparam int BIT_BYTE_ORDER = 0;
  localparam int BIT_RESERVED1 = 1;
  localparam int BIT_BOOT_ROM_DIS = 2;
  localparam int BIT_PARITY_MASK = 3;
  localparam int BIT_DEFER_DIS = 4;
  localparam int BIT_WIN_START = 5;
  localparam int BIT_SINGLE_BACKOFF = 6;
  localparam int BIT_REQ_POLICY = 7;
  localparam int BIT_LEGACY_DESC = 8;
  localparam int BIT_XCVR_DIS = 9;
  localparam int BIT_XCVR_RST = 10;
  localparam int BIT_EXT_XCVR = 12;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_WMASK = 32'h0000_17fd;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_DEFER = 0;
  localparam int IRQ_PARITY = 1;
  localparam int IRQ_XCVR_RST = 2;
  localparam logic [2:0] DESC_WORDS_LEGACY = 3'h4;
  localparam logic [2:0] DESC_WORDS_SHORT = 3'h3;
  localparam int SLOT_BITS = 512;
endpackage : dccb_pkg

/* rtl/dccb_swap.sv */
// Byte lane reverser for bus-master words.
// Assumes the data path feeds one word per cycle.
`timescale 1ns/1ps
`default_nettype none
module dccb_swap (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  output logic out_valid,
  output logic [31:0] out_data
);
  logic [31:0] swapped;
  assign swapped = enable ? {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]}
                          : in_data;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 32'h0000_0000;
    end else begin
      out_valid <= in_valid;
      out_data <= swapped;
    end
  end
endmodule : dccb_swap
`default_nettype wire

/* rtl/dccb_top.sv */
// Configuration control bits with AHB-Lite register access.
// Assumes one AHB master, single word transfers, one clock.
// How it works
// - Transceiver reset held while bit set
// - Disable bit powers down transceiver
// - Legacy format fetches four words, one fragment
// - Short format fetches three words, pointer third
// - Policy bit picks aggressive or conservative requests
// - Single back-off bit forces one slot
// - Window start bit picks collision timer start
// - Deferral disable blocks flag and counter
// - Parity mask bit gates system error
// - Boot ROM disable stops ROM logic
// - Byte order bit selects big endian
// - Register access ignores byte order bit
// - External select enables MII, disables transceiver
`timescale 1ns/1ps
`default_nettype none
module dccb_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic excess_defer_event,
  input wire logic master_parity_error,
  input wire logic dma_in_valid,
  input wire logic [31:0] dma_in_data,
  output logic dma_out_valid,
  output logic [31:0] dma_out_data,
  output logic internal_xcvr_reset,
  output logic internal_xcvr_disable,
  output logic mii_enable,
  output logic legacy_descriptor_format,
  output logic [2:0] desc_fetch_words,
  output logic frag_ptr_in_word3,
  output logic frag_count_ignore,
  output logic bus_request_policy,
  output logic forced_single_backoff,
  output logic collision_window_start_sel,
  output logic [9:0] collision_slot_bits,
  output logic deferral_timeout_disable,
  output logic excessive_deferral_flag,
  output logic [15:0] deferral_error_counter,
  output logic serr_req,
  output logic boot_rom_disable,
  output logic boot_rom_enable,
  output logic bus_master_byte_order,
  output logic irq
);
  logic [31:0] config_q;
  logic [31:0] config_d;
  logic [2:0] irq_status_q;
  logic [2:0] irq_status_d;
  logic [2:0] irq_enable_q;
  logic [15:0] defer_cnt_q;
  logic defer_flag_q;
  logic serr_q;
  logic xrst_prev_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr;
  logic addr_phase;
  logic wr_cfg;
  logic wr_ien;
  logic wr_iclr;
  logic [2:0] clr_bits;
  logic [2:0] events;
  logic defer_ok;
  logic parity_ok;
  logic xrst_fall;
  logic [31:0] rd_mux;

  function automatic logic [31:0] dccb_cfg_merge(input logic [31:0] old_v, input logic [31:0] w);
    logic [31:0] r;
    r = (old_v & ~dccb_pkg::CONFIG_WMASK) | (w & dccb_pkg::CONFIG_WMASK);
    r[dccb_pkg::BIT_RESERVED1] = 1'b0;
    if (w[dccb_pkg::BIT_EXT_XCVR]) begin
      r[dccb_pkg::BIT_XCVR_DIS] = 1'b1;
    end
    return r;
  endfunction : dccb_cfg_merge

  assign addr_phase = hsel && hready && htrans[1];
  assign rd_addr = haddr[7:0];
  assign wr_cfg = wr_pend_q && (wr_addr_q == dccb_pkg::OFF_CONFIG);
  assign wr_ien = wr_pend_q && (wr_addr_q == dccb_pkg::OFF_IRQ_ENABLE);
  assign wr_iclr = wr_pend_q && (wr_addr_q == dccb_pkg::OFF_IRQ_CLEAR);
  // Register data use native lanes, no swap applied
  assign config_d = wr_cfg ? dccb_cfg_merge(config_q, hwdata) : config_q;
  assign clr_bits = wr_iclr ? hwdata[2:0] : 3'h0;

  assign internal_xcvr_reset = config_q[dccb_pkg::BIT_XCVR_RST];
  assign internal_xcvr_disable = config_q[dccb_pkg::BIT_XCVR_DIS];
  assign mii_enable = config_q[dccb_pkg::BIT_EXT_XCVR];
  assign legacy_descriptor_format = config_q[dccb_pkg::BIT_LEGACY_DESC];
  assign desc_fetch_words = legacy_descriptor_format ? dccb_pkg::DESC_WORDS_LEGACY
                                                     : dccb_pkg::DESC_WORDS_SHORT;
  assign frag_count_ignore = legacy_descriptor_format;
  assign frag_ptr_in_word3 = !legacy_descriptor_format;
  assign bus_request_policy = config_q[dccb_pkg::BIT_REQ_POLICY];
  assign forced_single_backoff = config_q[dccb_pkg::BIT_SINGLE_BACKOFF];
  assign collision_window_start_sel = config_q[dccb_pkg::BIT_WIN_START];
  assign collision_slot_bits = 10'(dccb_pkg::SLOT_BITS);
  assign deferral_timeout_disable = config_q[dccb_pkg::BIT_DEFER_DIS];
  assign boot_rom_disable = config_q[dccb_pkg::BIT_BOOT_ROM_DIS];
  assign boot_rom_enable = !boot_rom_disable;
  assign bus_master_byte_order = config_q[dccb_pkg::BIT_BYTE_ORDER];

  assign defer_ok = excess_defer_event && !deferral_timeout_disable;
  assign parity_ok = master_parity_error && !config_q[dccb_pkg::BIT_PARITY_MASK];
  assign xrst_fall = xrst_prev_q && !internal_xcvr_reset;
  assign events = {xrst_fall, parity_ok, defer_ok};
  // Set wins over clear
  assign irq_status_d = (irq_status_q & ~clr_bits) | events;
  assign irq = |(irq_status_q & irq_enable_q);

  assign excessive_deferral_flag = defer_flag_q;
  assign deferral_error_counter = defer_cnt_q;
  assign serr_req = serr_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr)
      dccb_pkg::OFF_CONFIG: rd_mux = config_q;
      dccb_pkg::OFF_IRQ_STATUS: rd_mux = {29'h0, irq_status_q};
      dccb_pkg::OFF_IRQ_ENABLE: rd_mux = {29'h0, irq_enable_q};
      dccb_pkg::OFF_DEFER_COUNT: rd_mux = {16'h0000, defer_cnt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= rd_addr;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= dccb_pkg::CONFIG_RESET;
      irq_status_q <= 3'h0;
      irq_enable_q <= 3'h0;
      xrst_prev_q <= 1'b0;
    end else begin
      config_q <= config_d;
      irq_status_q <= irq_status_d;
      if (wr_ien) begin
        irq_enable_q <= hwdata[2:0];
      end
      xrst_prev_q <= internal_xcvr_reset;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      defer_flag_q <= 1'b0;
      defer_cnt_q <= 16'h0000;
      serr_q <= 1'b0;
    end else begin
      defer_flag_q <= defer_ok;
      if (defer_ok && defer_cnt_q != 16'hffff) begin
        defer_cnt_q <= defer_cnt_q + 16'h0001;
      end
      serr_q <= parity_ok;
    end
  end

  dccb_swap u_swap (
    .clock(clock),
    .rst_n(rst_n),
    .enable(bus_master_byte_order),
    .in_valid(dma_in_valid),
    .in_data(dma_in_data),
    .out_valid(dma_out_valid),
    .out_data(dma_out_data)
  );

  property p_xcvr_rst_hold;
    @(posedge clock) disable iff (!rst_n)
      (internal_xcvr_reset && !wr_cfg) |=> internal_xcvr_reset;
  endproperty
  a_xcvr_rst_hold: assert property (p_xcvr_rst_hold) else $error("reset bit cleared itself");

  property p_xcvr_dis;
    @(posedge clock) disable iff (!rst_n)
      wr_cfg |=> internal_xcvr_disable == ($past(hwdata[dccb_pkg::BIT_XCVR_DIS]) ||
        $past(hwdata[dccb_pkg::BIT_EXT_XCVR]));
  endproperty
  a_xcvr_dis: assert property (p_xcvr_dis) else $error("disable output wrong");

  property p_desc_words;
    @(posedge clock) disable iff (!rst_n)
      legacy_descriptor_format ? (desc_fetch_words == 3'h4 && frag_count_ignore)
                               : (desc_fetch_words == 3'h3 && frag_ptr_in_word3);
  endproperty
  a_desc_words: assert property (p_desc_words) else $error("descriptor size wrong");

  property p_defer_block;
    @(posedge clock) disable iff (!rst_n)
      deferral_timeout_disable |=> (!excessive_deferral_flag && $stable(deferral_error_counter));
  endproperty
  a_defer_block: assert property (p_defer_block) else $error("deferral logged while disabled");

  property p_parity_serr;
    @(posedge clock) disable iff (!rst_n)
      (master_parity_error && !config_q[dccb_pkg::BIT_PARITY_MASK]) |=> serr_req;
  endproperty
  a_parity_serr: assert property (p_parity_serr) else $error("SERR missing");

  property p_parity_mask;
    @(posedge clock) disable iff (!rst_n)
      config_q[dccb_pkg::BIT_PARITY_MASK] |=> !serr_req;
  endproperty
  a_parity_mask: assert property (p_parity_mask) else $error("SERR while masked");

  property p_rom_dis;
    @(posedge clock) disable iff (!rst_n)
      wr_cfg |=> boot_rom_enable == !$past(hwdata[dccb_pkg::BIT_BOOT_ROM_DIS]);
  endproperty
  a_rom_dis: assert property (p_rom_dis) else $error("ROM logic active");

  property p_swap;
    @(posedge clock) disable iff (!rst_n)
      (dma_in_valid && bus_master_byte_order) |=> (dma_out_valid &&
        dma_out_data == {$past(dma_in_data[7:0]), $past(dma_in_data[15:8]),
          $past(dma_in_data[23:16]), $past(dma_in_data[31:24])});
  endproperty
  a_swap: assert property (p_swap) else $error("byte lanes not reversed");

  property p_ext_sets_dis;
    @(posedge clock) disable iff (!rst_n)
      (wr_cfg && hwdata[dccb_pkg::BIT_EXT_XCVR]) |=> (internal_xcvr_disable && mii_enable);
  endproperty
  a_ext_sets_dis: assert property (p_ext_sets_dis) else $error("external select no effect");

  property p_resv_zero;
    @(posedge clock) disable iff (!rst_n)
      !config_q[dccb_pkg::BIT_RESERVED1];
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit set");

  property p_no_swap;
    @(posedge clock) disable iff (!rst_n)
      (dma_in_valid && !bus_master_byte_order) |=>
        (dma_out_valid && dma_out_data == $past(dma_in_data));
  endproperty
  a_no_swap: assert property (p_no_swap) else $error("little endian word altered");

  property p_cfg_modes;
    @(posedge clock) disable iff (!rst_n)
      wr_cfg |=> (bus_request_policy == $past(hwdata[dccb_pkg::BIT_REQ_POLICY]) &&
        forced_single_backoff == $past(hwdata[dccb_pkg::BIT_SINGLE_BACKOFF]) &&
        collision_window_start_sel == $past(hwdata[dccb_pkg::BIT_WIN_START]) &&
        bus_master_byte_order == $past(hwdata[dccb_pkg::BIT_BYTE_ORDER]));
  endproperty
  a_cfg_modes: assert property (p_cfg_modes) else $error("mode bit not taken");

  property p_regs_native;
    @(posedge clock) disable iff (!rst_n)
      (addr_phase && !hwrite && rd_addr == dccb_pkg::OFF_CONFIG && bus_master_byte_order)
        |=> hrdata == $past(config_q);
  endproperty
  a_regs_native: assert property (p_regs_native) else $error("register read swapped");

  property p_mii_dis;
    @(posedge clock) disable iff (!rst_n)
      mii_enable |-> internal_xcvr_disable;
  endproperty
  a_mii_dis: assert property (p_mii_dis) else $error("transceiver on with MII");

  property p_set_wins;
    @(posedge clock) disable iff (!rst_n)
      (events != 3'h0) |=> ((irq_status_q & $past(events)) == $past(events));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in status");

  c_cfg_write: cover property (@(posedge clock) disable iff (!rst_n) wr_cfg);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
  c_serr: cover property (@(posedge clock) disable iff (!rst_n) serr_req);
  c_big_endian: cover property (@(posedge clock) disable iff (!rst_n)
    dma_out_valid && bus_master_byte_order);
  c_ext_xcvr: cover property (@(posedge clock) disable iff (!rst_n) mii_enable);
endmodule : dccb_top
`default_nettype wire

/* bench/dccb_partner.sv */
// Bus-master word source standing in for the host memory side.
// Assumes the bench pulses send for one cycle per word.
`timescale 1ns/1ps
`default_nettype none
module dccb_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic send,
  input wire logic [31:0] word,
  output logic valid,
  output logic [31:0] data
);
  // Idle data toggles so a stale word never looks valid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      data <= '0;
    end else begin
      valid <= send;
      data <= send ? word : ~data;
    end
  end
endmodule : dccb_partner
`default_nettype wire

/* bench/test_device_config_control_bits.sv */
// Testbench for the configuration control bits block.
// Assumes one AHB-Lite slave whose hreadyout serves as hready.
`timescale 1ns/1ps
`default_nettype none
module test_device_config_control_bits;
  localparam logic [7:0] A_CONF = dccb_pkg::OFF_CONFIG;
  localparam logic [7:0] A_STAT = dccb_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] A_EN = dccb_pkg::OFF_IRQ_ENABLE;
  localparam logic [7:0] A_CLR = dccb_pkg::OFF_IRQ_CLEAR;
  localparam logic [7:0] A_CNT = dccb_pkg::OFF_DEFER_COUNT;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0;
  logic excess_defer_event = 1'b0, master_parity_error = 1'b0, s;
  logic [31:0] haddr = '0, hwdata = '0, word = '0, rd, w;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, dma_in_valid, dma_out_valid, internal_xcvr_reset, irq;
  logic internal_xcvr_disable, mii_enable, legacy_descriptor_format, frag_ptr_in_word3;
  logic frag_count_ignore, bus_request_policy, forced_single_backoff, boot_rom_enable;
  logic collision_window_start_sel, deferral_timeout_disable, excessive_deferral_flag;
  logic serr_req, boot_rom_disable, bus_master_byte_order;
  logic [31:0] hrdata, dma_in_data, dma_out_data;
  logic [2:0] desc_fetch_words;
  logic [9:0] collision_slot_bits;
  logic [15:0] deferral_error_counter;
  int miscompares = 0, checks_done = 0;
  dccb_top dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .excess_defer_event,
    .master_parity_error, .dma_in_valid, .dma_in_data, .dma_out_valid, .dma_out_data,
    .internal_xcvr_reset, .internal_xcvr_disable, .mii_enable, .legacy_descriptor_format,
    .desc_fetch_words, .frag_ptr_in_word3, .frag_count_ignore, .bus_request_policy,
    .forced_single_backoff, .collision_window_start_sel, .collision_slot_bits,
    .deferral_timeout_disable, .excessive_deferral_flag, .deferral_error_counter,
    .serr_req, .boot_rom_disable, .boot_rom_enable, .bus_master_byte_order, .irq);
  dccb_partner host (.clock, .rst_n, .send, .word, .valid(dma_in_valid),
    .data(dma_in_data));
  always #5 clock = ~clock;
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    logic late;
    n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    late = (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (late || hreadyout !== 1'b1 || hresp !== 1'b0) begin
      miscompares++;
      summarize();
    end
    #1;
  endtask : xfer
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, '0);
    check(what, exp, rd);
  endtask : rdchk
  task automatic cfg_outs(input logic [31:0] e);
    logic [31:0] o;
    o = {19'h0, mii_enable, 1'b0, internal_xcvr_reset, internal_xcvr_disable,
      legacy_descriptor_format, bus_request_policy, forced_single_backoff,
      collision_window_start_sel, deferral_timeout_disable, 1'b0, boot_rom_disable,
      1'b0, bus_master_byte_order};
    check("config outputs", e & 32'h0000_17f5, o);
    check("descriptor and rom", {26'h0, e[8] ? 3'h4 : 3'h3, !e[8], e[8], !e[2]},
      {26'h0, desc_fetch_words, frag_ptr_in_word3, frag_count_ignore, boot_rom_enable});
  endtask : cfg_outs
  task automatic pulse(input logic par, output logic seen);
    seen = 1'b0;
    @(posedge clock);
    excess_defer_event <= !par;
    master_parity_error <= par;
    @(posedge clock);
    excess_defer_event <= 1'b0;
    master_parity_error <= 1'b0;
    repeat (3) begin
      #1;
      seen |= par ? serr_req : excessive_deferral_flag;
      @(posedge clock);
    end
    #1;
  endtask : pulse
  task automatic swap(input logic [31:0] x, output logic [31:0] got);
    got = 'x;
    @(posedge clock);
    send <= 1'b1;
    word <= x;
    @(posedge clock);
    send <= 1'b0;
    repeat (4) begin
      #1;
      if (dma_out_valid === 1'b1) got = dma_out_data;
      @(posedge clock);
    end
  endtask : swap
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rdchk("config reset", A_CONF, 32'h0);
    check("slot bits", 32'h0000_0200, {22'h0, collision_slot_bits});
    cfg_outs(32'h0);
    $display("test reset done");
    for (int b = 0; b < 13; b++) begin
      logic [31:0] e;
      e = (32'h1 << b) & 32'h0000_17fd;
      if (b == 12) e[9] = 1'b1;
      xfer(1'b1, A_CONF, 32'h1 << b);
      rdchk("config bit", A_CONF, e);
      cfg_outs(e);
    end
    rdchk("status", A_STAT, 32'h4);
    check("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, A_EN, 32'h7);
    check("irq enabled", 32'h1, {31'h0, irq});
    xfer(1'b1, A_CLR, 32'h4);
    rdchk("status cleared", A_STAT, 32'h0);
    check("irq cleared", 32'h0, {31'h0, irq});
    $display("test config bits done");
    xfer(1'b1, A_CONF, 32'h0);
    pulse(1'b0, s);
    check("deferral flag", 32'h1, {31'h0, s});
    rdchk("deferral count", A_CNT, 32'h1);
    check("counter output", 32'h0000_0001, {16'h0, deferral_error_counter});
    check("irq on event", 32'h1, {31'h0, irq});
    xfer(1'b1, A_CLR, 32'h7);
    xfer(1'b1, A_CONF, 32'h0000_0010);
    pulse(1'b0, s);
    check("deferral blocked", 32'h0, {31'h0, s});
    rdchk("count held", A_CNT, 32'h1);
    rdchk("status quiet", A_STAT, 32'h0);
    xfer(1'b1, A_CONF, 32'h0);
    pulse(1'b1, s);
    check("system error", 32'h1, {31'h0, s});
    xfer(1'b1, A_CONF, 32'h8);
    pulse(1'b1, s);
    check("system error masked", 32'h0, {31'h0, s});
    $display("test events done");
    xfer(1'b1, A_CONF, 32'h0000_0101);
    rdchk("config big endian", A_CONF, 32'h0000_0101);
    swap(32'h1122_3344, w);
    check("swapped word", 32'h4433_2211, w);
    xfer(1'b1, A_CONF, 32'h0);
    swap(32'h1122_3344, w);
    check("plain word", 32'h1122_3344, w);
    $display("test byte order done");
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    rdchk("unmapped", 8'h20, 32'h0);
    xfer(1'b1, A_CNT, 32'h0000_0055);
    rdchk("count read only", A_CNT, 32'h1);
    $display("test access done");
    summarize();
  end
endmodule : test_device_config_control_bits
`default_nettype wire
